// ### inc/aif_pkg.sv
package aif_pkg;
  // Register pages; byte address is {page, word index, 2'b00}
  localparam int unsigned ADDR_W = 9;
  localparam logic [2:0] PG_TWO_IN = 3'h0;
  localparam logic [2:0] PG_TWO_OUT = 3'h1;
  localparam logic [2:0] PG_FOUR_IN = 3'h2;
  localparam logic [2:0] PG_FOUR_OUT_ST = 3'h3;
  localparam logic [2:0] PG_FOUR_OUT = 3'h4;
  localparam logic [2:0] PG_CTRL = 3'h5;

  // Word indices within a page
  localparam logic [3:0] IDX_CH0 = 4'h0;
  localparam logic [3:0] IDX_CH1 = 4'h1;
  localparam logic [3:0] IDX_CH2 = 4'h2;
  localparam logic [3:0] IDX_CH3 = 4'h3;
  localparam logic [3:0] IDX_IN_STATUS = 4'h4;
  localparam logic [3:0] IDX_IN_RANGE = 4'h5;
  localparam logic [3:0] IDX_OUT_STATUS = 4'h0;
  localparam logic [3:0] IDX_OUT_RANGE = 4'h1;
  localparam logic [3:0] IDX_CTRL = 4'h0;

  // Converter code scale: 32760 full scale, 15 bits
  localparam logic [14:0] RAW_FULL = 15'h7FF8;
  localparam logic [15:0] SCALED_FULL = 16'h3FFC;
  localparam logic [15:0] RAW_DATA_MASK = 16'h7FF8;
  localparam logic [15:0] SCALED_DATA_MASK = 16'h3FFC;
  localparam logic [15:0] RAW_WR_MASK = 16'hFFF8;
  localparam logic [15:0] SCALED_WR_MASK = 16'hFFFC;
  localparam int unsigned SIGN_BIT = 15;
  localparam int unsigned OVR_BIT = 14;

  // Control register fields
  localparam int unsigned CTRL_W = 3;
  localparam int unsigned CTRL_TWO_FMT = 0;
  localparam int unsigned CTRL_FOUR_IN_FMT = 1;
  localparam int unsigned CTRL_FOUR_OUT_FMT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  typedef enum logic {AIF_BUS_IDLE, AIF_BUS_ACK} aif_bus_e;
endpackage

// ### rtl/aif_in_fmt.sv
module aif_in_fmt (
  input wire logic [14:0] code,
  input wire logic over,
  input wire logic under,
  input wire logic scaled,
  output logic [15:0] word
);
  logic [14:0] lim;

  always_comb begin
    // Over-range converts at full scale, never above it
    if (over || (code > aif_pkg::RAW_FULL)) begin
      lim = aif_pkg::RAW_FULL;
    end else if (under) begin
      lim = 15'h0000;
    end else begin
      lim = code;
    end
    // Scaled is exactly half of raw, so 32760 maps to 16380
    if (scaled) begin
      word = {2'b00, lim[14:1]} & aif_pkg::SCALED_DATA_MASK;
    end else begin
      word = {1'b0, lim} & aif_pkg::RAW_DATA_MASK;
    end
  end
endmodule

// ### rtl/aif_out_dec.sv
module aif_out_dec (
  input wire logic [15:0] word,
  input wire logic scaled,
  output logic [14:0] code,
  output logic over,
  output logic under
);
  always_comb begin
    over = 1'b0;
    under = 1'b0;
    if (word[aif_pkg::SIGN_BIT]) begin
      // Negative request: hold at zero volts or zero milliamps
      under = 1'b1;
      code = 15'h0000;
    end else if (scaled && word[aif_pkg::OVR_BIT]) begin
      over = 1'b1;
      code = aif_pkg::RAW_FULL;
    end else if (scaled) begin
      code = {word[13:2], 3'b000};
    end else begin
      code = word[14:0] & aif_pkg::RAW_FULL;
    end
  end
endmodule

// ### rtl/aif_fmt_top.sv
// Notes on behaviour
// - Voltage full scale 10.5 V is 32760 raw, 16380 scaled; zero is zero.
// - Current 21/20/4/0 mA map to 32760/31200/6240/0 raw, half that scaled.
// - Two-channel module selects raw or scaled; inputs in words 0, 1; 2, 3 reserved.
// - Raw keeps bits 15, 2..0 zero; scaled keeps bits 15, 14, 1, 0 zero.
// - Two-channel status in word 4 bits 1..0; under/over pairs in word 5 15..12.
// - Status flag set on over-range, under-range or module hardware fault.
// - Two-channel output words 0, 1 keep the selected format's low zero bits (2..0 raw, 1..0 scaled).
// - Four-input words 0..3 carry sign in bit 15; word 4 status; word 6 reserved.
// - Four-input under/over pairs for channels 0..3 in word 5 bits 15..8.
// - Over-range flag follows the condition; data held at full-range maximum.
// - Under-range flag follows the condition and clears by itself.
// - Four-output status in word 0 bits 3..0, pairs in word 1 bits 7..0.
// - Output over-range drives maximum full-range value; flag clears when error ends.
// - Output under-range drives minimum full-range value; flag clears when error ends.
// - Four-output channel values come from output words 0..3, raw 0..32760.
// - Raw output ignores bits 2..0; bit 15 set forces output to zero.
// - Scaled output accepts 0..16380, ignores bits 1..0; bit 15 forces zero.
// - Scaled output with bit 15 clear and bit 14 set drives 10.5 V or 21 mA.
module aif_fmt_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [1:0][14:0] two_in_code,
  input wire logic [1:0] two_in_over,
  input wire logic [1:0] two_in_under,
  input wire logic two_hw_fault,
  input wire logic [3:0][14:0] four_in_code,
  input wire logic [3:0] four_in_sign,
  input wire logic [3:0] four_in_over,
  input wire logic [3:0] four_in_under,
  input wire logic four_in_hw_fault,
  input wire logic four_out_hw_fault,
  output logic [1:0][14:0] two_out_code,
  output logic [3:0][14:0] four_out_code
);
  aif_pkg::aif_bus_e bus_q;
  logic [aif_pkg::CTRL_W-1:0] ctrl_q;
  logic [1:0][15:0] two_in_word_q;
  logic [1:0] two_in_over_q;
  logic [1:0] two_in_under_q;
  logic [1:0] two_stat_q;
  logic [3:0][15:0] four_in_word_q;
  logic [3:0] four_in_over_q;
  logic [3:0] four_in_under_q;
  logic [3:0] four_in_stat_q;
  logic [1:0][15:0] two_out_word_q;
  logic [3:0][15:0] four_out_word_q;
  logic [3:0] four_out_over_q;
  logic [3:0] four_out_under_q;
  logic [3:0] four_out_stat_q;
  logic [1:0][15:0] two_in_fmt;
  logic [3:0][15:0] four_in_fmt;
  logic [1:0][14:0] two_out_dec;
  logic [3:0][14:0] four_out_dec;
  logic [3:0] four_out_over_d;
  logic [3:0] four_out_under_d;
  logic [2:0] page;
  logic [3:0] idx;
  logic wr_en;
  logic [15:0] rd_word;

  logic two_scaled;
  logic four_in_scaled;
  logic four_out_scaled;

  assign two_scaled = ctrl_q[aif_pkg::CTRL_TWO_FMT];
  assign four_in_scaled = ctrl_q[aif_pkg::CTRL_FOUR_IN_FMT];
  assign four_out_scaled = ctrl_q[aif_pkg::CTRL_FOUR_OUT_FMT];
  assign page = avs_address[8:6];
  assign idx = avs_address[5:2];
  // A write lands only at the edge where the master sees waitrequest low
  assign wr_en = ce && avs_write && (bus_q == aif_pkg::AIF_BUS_ACK);

  function automatic logic [15:0] merge_word(input logic [15:0] old, input logic [31:0] wd,
                                             input logic [3:0] be, input logic scaled);
    logic [15:0] nw;
    nw = old;
    if (be[0]) begin
      nw[7:0] = wd[7:0];
    end
    if (be[1]) begin
      nw[15:8] = wd[15:8];
    end
    merge_word = nw & (scaled ? aif_pkg::SCALED_WR_MASK : aif_pkg::RAW_WR_MASK);
  endfunction

  function automatic logic [7:0] pairs4(input logic [3:0] u, input logic [3:0] o);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 4; i++) begin
      p[7 - 2 * i] = u[i];
      p[6 - 2 * i] = o[i];
    end
    pairs4 = p;
  endfunction

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_two
      aif_in_fmt u_in (
        .code(two_in_code[g]),
        .over(two_in_over[g]),
        .under(two_in_under[g]),
        .scaled(two_scaled),
        .word(two_in_fmt[g])
      );
      aif_out_dec u_out (
        .word(two_out_word_q[g]),
        .scaled(two_scaled),
        .code(two_out_dec[g]),
        .over(),
        .under()
      );
    end
    for (g = 0; g < 4; g++) begin : g_four
      aif_in_fmt u_in (
        .code(four_in_code[g]),
        .over(four_in_over[g]),
        .under(four_in_under[g]),
        .scaled(four_in_scaled),
        .word(four_in_fmt[g])
      );
      aif_out_dec u_out (
        .word(four_out_word_q[g]),
        .scaled(four_out_scaled),
        .code(four_out_dec[g]),
        .over(four_out_over_d[g]),
        .under(four_out_under_d[g])
      );
    end
  endgenerate

  // Bus handshake: one wait state, then a single low cycle of waitrequest
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_q <= aif_pkg::AIF_BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end else if (ce) begin
      case (bus_q)
        aif_pkg::AIF_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_q <= aif_pkg::AIF_BUS_ACK;
            avs_waitrequest <= 1'b0;
          end
        end
        aif_pkg::AIF_BUS_ACK: begin
          bus_q <= aif_pkg::AIF_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_q <= aif_pkg::AIF_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    rd_word = 16'h0000;
    case (page)
      aif_pkg::PG_TWO_IN: begin
        case (idx)
          aif_pkg::IDX_CH0: rd_word = two_in_word_q[0];
          aif_pkg::IDX_CH1: rd_word = two_in_word_q[1];
          aif_pkg::IDX_IN_STATUS: rd_word = {14'h0000, two_stat_q};
          aif_pkg::IDX_IN_RANGE: begin
            rd_word = {two_in_under_q[0], two_in_over_q[0], two_in_under_q[1], two_in_over_q[1], 12'h000};
          end
          default: rd_word = 16'h0000;
        endcase
      end
      aif_pkg::PG_TWO_OUT: begin
        case (idx)
          aif_pkg::IDX_CH0: rd_word = two_out_word_q[0];
          aif_pkg::IDX_CH1: rd_word = two_out_word_q[1];
          default: rd_word = 16'h0000;
        endcase
      end
      aif_pkg::PG_FOUR_IN: begin
        case (idx)
          aif_pkg::IDX_CH0: rd_word = four_in_word_q[0];
          aif_pkg::IDX_CH1: rd_word = four_in_word_q[1];
          aif_pkg::IDX_CH2: rd_word = four_in_word_q[2];
          aif_pkg::IDX_CH3: rd_word = four_in_word_q[3];
          aif_pkg::IDX_IN_STATUS: rd_word = {12'h000, four_in_stat_q};
          aif_pkg::IDX_IN_RANGE: rd_word = {pairs4(four_in_under_q, four_in_over_q), 8'h00};
          default: rd_word = 16'h0000;
        endcase
      end
      aif_pkg::PG_FOUR_OUT_ST: begin
        case (idx)
          aif_pkg::IDX_OUT_STATUS: rd_word = {12'h000, four_out_stat_q};
          aif_pkg::IDX_OUT_RANGE: rd_word = {8'h00, pairs4(four_out_under_q, four_out_over_q)};
          default: rd_word = 16'h0000;
        endcase
      end
      aif_pkg::PG_FOUR_OUT: begin
        case (idx)
          aif_pkg::IDX_CH0: rd_word = four_out_word_q[0];
          aif_pkg::IDX_CH1: rd_word = four_out_word_q[1];
          aif_pkg::IDX_CH2: rd_word = four_out_word_q[2];
          aif_pkg::IDX_CH3: rd_word = four_out_word_q[3];
          default: rd_word = 16'h0000;
        endcase
      end
      aif_pkg::PG_CTRL: begin
        if (idx == aif_pkg::IDX_CTRL) begin
          rd_word = {13'h0000, ctrl_q};
        end
      end
      default: rd_word = 16'h0000;
    endcase
  end

  // Read data captured as waitrequest drops, then held until the next read
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (ce && avs_read && (bus_q == aif_pkg::AIF_BUS_IDLE)) begin
      avs_readdata <= {16'h0000, rd_word};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= aif_pkg::CTRL_RESET;
    end else if (wr_en && (page == aif_pkg::PG_CTRL) && (idx == aif_pkg::IDX_CTRL) && avs_byteenable[0]) begin
      ctrl_q <= avs_writedata[aif_pkg::CTRL_W-1:0];
    end
  end

  // Masking at write time keeps the fixed zero bits zero even if software slips
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      two_out_word_q <= '0;
    end else if (wr_en && (page == aif_pkg::PG_TWO_OUT)) begin
      for (int i = 0; i < 2; i++) begin
        if (idx == 4'(i)) begin
          two_out_word_q[i] <= merge_word(two_out_word_q[i], avs_writedata, avs_byteenable, two_scaled);
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      four_out_word_q <= '0;
    end else if (wr_en && (page == aif_pkg::PG_FOUR_OUT)) begin
      for (int i = 0; i < 4; i++) begin
        if (idx == 4'(i)) begin
          four_out_word_q[i] <= merge_word(four_out_word_q[i], avs_writedata, avs_byteenable,
                                           four_out_scaled);
        end
      end
    end
  end

  // Input images refresh every enabled cycle; flags track the live condition
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      two_in_word_q <= '0;
      two_in_over_q <= 2'h0;
      two_in_under_q <= 2'h0;
      two_stat_q <= 2'h0;
    end else if (ce) begin
      two_in_word_q <= two_in_fmt;
      two_in_over_q <= two_in_over;
      two_in_under_q <= two_in_under;
      two_stat_q <= two_in_over | two_in_under | {2{two_hw_fault}};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      four_in_word_q <= '0;
      four_in_over_q <= 4'h0;
      four_in_under_q <= 4'h0;
      four_in_stat_q <= 4'h0;
    end else if (ce) begin
      for (int i = 0; i < 4; i++) begin
        four_in_word_q[i] <= {four_in_sign[i], four_in_fmt[i][14:0]};
      end
      four_in_over_q <= four_in_over;
      four_in_under_q <= four_in_under;
      four_in_stat_q <= four_in_over | four_in_under | {4{four_in_hw_fault}};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      four_out_over_q <= 4'h0;
      four_out_under_q <= 4'h0;
      four_out_stat_q <= 4'h0;
    end else if (ce) begin
      four_out_over_q <= four_out_over_d;
      four_out_under_q <= four_out_under_d;
      four_out_stat_q <= four_out_over_d | four_out_under_d | {4{four_out_hw_fault}};
    end
  end

  // Converter codes lag the written word by one enabled cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      two_out_code <= '0;
      four_out_code <= '0;
    end else if (ce) begin
      two_out_code <= two_out_dec;
      four_out_code <= four_out_dec;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_over_then_clear;
    (ce && four_in_over[2]) ##1 (ce && !four_in_over[2]);
  endsequence

  sequence s_under_then_clear;
    (ce && four_in_under[1]) ##1 (ce && !four_in_under[1]);
  endsequence

  sequence s_bus_req;
    ce && (avs_read || avs_write) && (bus_q == aif_pkg::AIF_BUS_IDLE);
  endsequence

  AST_RAW_FULL_SCALE: assert property (ce && two_in_over[0] && !two_scaled |=> two_in_word_q[0] == 16'h7FF8)
    else $error("raw over-range word is not full scale");
  AST_SCALED_HALF: assert property (ce && two_scaled && !two_in_over[1] && !two_in_under[1]
      && (two_in_code[1] <= aif_pkg::RAW_FULL)
      |=> two_in_word_q[1] == ({2'b00, $past(two_in_code[1][14:1])} & 16'h3FFC))
    else $error("scaled word is not half of raw code");
  AST_ZERO_BITS: assert property (ce |=> (two_in_word_q[0] & ($past(two_scaled) ? 16'hC003 : 16'h8007)) == 16'h0000)
    else $error("fixed zero bits are set in input word");
  AST_STATUS_SET: assert property (ce && (two_in_under[1] || two_hw_fault) |=> two_stat_q[1])
    else $error("status flag missing on fault");
  AST_SIGN_BIT: assert property (ce |=> four_in_word_q[2][15] == $past(four_in_sign[2]))
    else $error("sign bit not carried to bit 15");
  AST_OVER_CLEARS: assert property (s_over_then_clear |=> !four_in_over_q[2] && four_in_stat_q[2] == $past(four_in_hw_fault || four_in_under[2]))
    else $error("over-range flag did not clear");
  AST_UNDER_CLEARS: assert property (s_under_then_clear |=> !four_in_under_q[1])
    else $error("under-range flag did not clear");
  AST_RANGE_ORDER: assert property (s_bus_req ##0 avs_read && page == aif_pkg::PG_FOUR_IN && idx == aif_pkg::IDX_IN_RANGE
      |=> avs_readdata[15:14] == {$past(four_in_under_q[0]), $past(four_in_over_q[0])}
      && avs_readdata[9:8] == {$past(four_in_under_q[3]), $past(four_in_over_q[3])} && avs_readdata[7:0] == 8'h00)
    else $error("range pair order wrong");
  AST_OUT_MAX: assert property (ce && four_out_scaled && four_out_word_q[2][15:14] == 2'b01
      |=> four_out_code[2] == 15'h7FF8 && four_out_over_q[2])
    else $error("overrange request not at full scale");
  AST_OUT_ZERO: assert property (ce && four_out_word_q[1][15] |=> four_out_code[1] == 15'h0000 && four_out_under_q[1])
    else $error("negative request not forced to zero");
  AST_BUS_ACK: assert property (s_bus_req |=> !avs_waitrequest)
    else $error("request not answered after one wait state");
  AST_BUS_RELEASE: assert property (ce && !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_WRITE_LANDS: assert property (wr_en && page == aif_pkg::PG_FOUR_OUT && idx == aif_pkg::IDX_CH0
      && avs_byteenable == 4'hF && !four_out_scaled
      |=> four_out_word_q[0] == ($past(avs_writedata[15:0]) & 16'hFFF8))
    else $error("output word write not stored");
endmodule

// ### tb/aif_conv_model.sv
module aif_conv_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  output logic [1:0][14:0] two_in_code,
  output logic [1:0] two_in_over,
  output logic [1:0] two_in_under,
  output logic two_hw_fault,
  output logic [3:0][14:0] four_in_code,
  output logic [3:0] four_in_sign,
  output logic [3:0] four_in_over,
  output logic [3:0] four_in_under,
  output logic four_in_hw_fault,
  output logic four_out_hw_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0][14:0] two_c = '0;
  logic [3:0] two_f = '0;
  logic [3:0][14:0] four_c = '0;
  logic [11:0] four_f = '0;
  logic [2:0] flt = '0;
  // Front end refreshes once a clock, so the bench never races the sampling edge
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {two_in_code, two_in_over, two_in_under, two_hw_fault} <= '0;
      {four_in_code, four_in_sign, four_in_over, four_in_under} <= '0;
      {four_in_hw_fault, four_out_hw_fault} <= '0;
    end else begin
      two_in_code <= two_c;
      {two_in_over, two_in_under} <= two_f;
      four_in_code <= four_c;
      {four_in_sign, four_in_over, four_in_under} <= four_f;
      {two_hw_fault, four_in_hw_fault, four_out_hw_fault} <= flt;
    end
  end
  task automatic set_two(input int ch, input logic [14:0] c, input logic o, input logic u);
    two_c[ch] = c;
    two_f[ch + 2] = o;
    two_f[ch] = u;
  endtask
  task automatic set_four(input int ch, input logic [14:0] c, input logic s, input logic o, input logic u);
    four_c[ch] = c;
    four_f[ch + 8] = s;
    four_f[ch + 4] = o;
    four_f[ch] = u;
  endtask
  task automatic set_faults(input logic [2:0] f);
    flt = f;
  endtask
endmodule

// ### tb/aif_fmt_top_tb.sv
module aif_fmt_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk;
  logic rst_n;
  logic ce;
  logic [8:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0][14:0] two_in_code;
  logic [1:0] two_in_over;
  logic [1:0] two_in_under;
  logic two_hw_fault;
  logic [3:0][14:0] four_in_code;
  logic [3:0] four_in_sign;
  logic [3:0] four_in_over;
  logic [3:0] four_in_under;
  logic four_in_hw_fault;
  logic four_out_hw_fault;
  logic [1:0][14:0] two_out_code;
  logic [3:0][14:0] four_out_code;
  logic [31:0] rd_val;
  logic [15:0] ev;
  int miscompares = 0;
  int check_count = 0;
  // Full scale, 20 mA, 4 mA, zero, and a code with low bits that must vanish
  logic [14:0] code_tab [5] = '{15'h7FF8, 15'h79E0, 15'h1860, 15'h0000, 15'h7FFF};

  aif_fmt_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .two_in_code(two_in_code), .two_in_over(two_in_over), .two_in_under(two_in_under),
    .two_hw_fault(two_hw_fault), .four_in_code(four_in_code), .four_in_sign(four_in_sign),
    .four_in_over(four_in_over), .four_in_under(four_in_under), .four_in_hw_fault(four_in_hw_fault),
    .four_out_hw_fault(four_out_hw_fault), .two_out_code(two_out_code), .four_out_code(four_out_code));

  aif_conv_model conv (.sys_clk(sys_clk), .rst_n(rst_n), .two_in_code(two_in_code),
    .two_in_over(two_in_over), .two_in_under(two_in_under), .two_hw_fault(two_hw_fault),
    .four_in_code(four_in_code), .four_in_sign(four_in_sign), .four_in_over(four_in_over),
    .four_in_under(four_in_under), .four_in_hw_fault(four_in_hw_fault),
    .four_out_hw_fault(four_out_hw_fault));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Sampled right at the rising edge, before the slave's own update lands
  task automatic bus(input logic wr, input logic [2:0] pg, input logic [3:0] ix, input logic [15:0] wd,
                     input logic [3:0] be);
    int n;
    logic ws;
    n = 0;
    @(posedge sys_clk);
    avs_address <= {pg, ix, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {16'h0000, wd};
    avs_byteenable <= be;
    do begin
      @(posedge sys_clk);
      ws = avs_waitrequest;
      n++;
    end while (ws !== 1'b0 && n < 50);
    rd_val = avs_readdata;
    if (ws !== 1'b0) check("bus handshake", {31'h0, ws}, 32'h0000_0000);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [2:0] pg, input logic [3:0] ix, input logic [15:0] wd);
    bus(1'b1, pg, ix, wd, 4'hF);
  endtask

  task automatic rc(input string name, input logic [2:0] pg, input logic [3:0] ix, input logic [15:0] exp);
    bus(1'b0, pg, ix, 16'h0000, 4'hF);
    check(name, rd_val, {16'h0000, exp});
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    check("watchdog", 32'h0000_0001, 32'h0000_0000);
    summarize();
  end

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hF;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    rc("control reset", aif_pkg::PG_CTRL, 4'h0, 16'h0000);
    rc("two out reset", aif_pkg::PG_TWO_OUT, 4'h0, 16'h0000);
    for (int f = 0; f < 2; f++) begin
      wr(aif_pkg::PG_CTRL, 4'h0, 16'(f));
      for (int k = 0; k < 5; k++) begin
        conv.set_two(0, code_tab[k], 1'b0, 1'b0);
        conv.set_two(1, code_tab[k], 1'b0, 1'b0);
        repeat (3) @(posedge sys_clk);
        ev = {1'b0, code_tab[k] & 15'h7FF8} >> f;
        rc("two in ch0", aif_pkg::PG_TWO_IN, 4'h0, ev);
        rc("two in ch1", aif_pkg::PG_TWO_IN, 4'h1, ev);
      end
      rc("two in word 2", aif_pkg::PG_TWO_IN, 4'h2, 16'h0000);
      rc("two in word 3", aif_pkg::PG_TWO_IN, 4'h3, 16'h0000);
    end
    wr(aif_pkg::PG_TWO_OUT, 4'h0, 16'h3FFF);
    rc("two out scaled", aif_pkg::PG_TWO_OUT, 4'h0, 16'h3FFC);
    check("two out code scaled", {17'h0, two_out_code[0]}, 32'h0000_7FF8);
    wr(aif_pkg::PG_CTRL, 4'h0, 16'h0000);
    wr(aif_pkg::PG_TWO_OUT, 4'h1, 16'h7FFF);
    rc("two out raw", aif_pkg::PG_TWO_OUT, 4'h1, 16'h7FF8);
    check("two out code raw", {17'h0, two_out_code[1]}, 32'h0000_7FF8);
    // Range flags on the two-channel side, then fault alone, then all clear
    conv.set_two(0, 15'h1000, 1'b1, 1'b0);
    conv.set_two(1, 15'h1000, 1'b0, 1'b1);
    repeat (3) @(posedge sys_clk);
    rc("two in over data", aif_pkg::PG_TWO_IN, 4'h0, 16'h7FF8);
    rc("two in range", aif_pkg::PG_TWO_IN, 4'h5, 16'h6000);
    rc("two in status", aif_pkg::PG_TWO_IN, 4'h4, 16'h0003);
    conv.set_two(0, 15'h1000, 1'b0, 1'b0);
    conv.set_two(1, 15'h1000, 1'b0, 1'b0);
    conv.set_faults(3'b100);
    repeat (3) @(posedge sys_clk);
    rc("two in range clear", aif_pkg::PG_TWO_IN, 4'h5, 16'h0000);
    rc("two in status fault", aif_pkg::PG_TWO_IN, 4'h4, 16'h0003);
    conv.set_faults(3'b000);
    repeat (3) @(posedge sys_clk);
    rc("two in status clear", aif_pkg::PG_TWO_IN, 4'h4, 16'h0000);
    wr(aif_pkg::PG_TWO_IN, 4'h4, 16'hFFFF);
    rc("read-only status", aif_pkg::PG_TWO_IN, 4'h4, 16'h0000);
    // Four-input: sign, under forces zero, over forces full scale
    conv.set_four(0, 15'h1860, 1'b1, 1'b0, 1'b0);
    conv.set_four(1, 15'h79E0, 1'b0, 1'b0, 1'b1);
    conv.set_four(2, 15'h1234, 1'b0, 1'b1, 1'b0);
    conv.set_four(3, 15'h000F, 1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge sys_clk);
    rc("four in ch0", aif_pkg::PG_FOUR_IN, 4'h0, 16'h9860);
    rc("four in ch1", aif_pkg::PG_FOUR_IN, 4'h1, 16'h0000);
    rc("four in ch2", aif_pkg::PG_FOUR_IN, 4'h2, 16'h7FF8);
    rc("four in ch3", aif_pkg::PG_FOUR_IN, 4'h3, 16'h0008);
    rc("four in range", aif_pkg::PG_FOUR_IN, 4'h5, 16'h2400);
    rc("four in status", aif_pkg::PG_FOUR_IN, 4'h4, 16'h0006);
    rc("four in word 6", aif_pkg::PG_FOUR_IN, 4'h6, 16'h0000);
    conv.set_four(1, 15'h79E0, 1'b0, 1'b0, 1'b0);
    conv.set_four(2, 15'h1234, 1'b0, 1'b0, 1'b0);
    conv.set_faults(3'b010);
    repeat (3) @(posedge sys_clk);
    rc("four in range clear", aif_pkg::PG_FOUR_IN, 4'h5, 16'h0000);
    rc("four in status fault", aif_pkg::PG_FOUR_IN, 4'h4, 16'h000F);
    conv.set_faults(3'b000);
    // Four-output raw: low bits dropped, bit 15 forces zero
    wr(aif_pkg::PG_FOUR_OUT, 4'h0, 16'h7FFF);
    wr(aif_pkg::PG_FOUR_OUT, 4'h1, 16'h8123);
    rc("four out ch0 raw", aif_pkg::PG_FOUR_OUT, 4'h0, 16'h7FF8);
    rc("four out ch1 raw", aif_pkg::PG_FOUR_OUT, 4'h1, 16'h8120);
    check("four out code0", {17'h0, four_out_code[0]}, 32'h0000_7FF8);
    check("four out code1", {17'h0, four_out_code[1]}, 32'h0000_0000);
    rc("four out range raw", aif_pkg::PG_FOUR_OUT_ST, 4'h1, 16'h0020);
    // Four-output scaled: bit 14 drives full scale, 3120 maps to 6240
    wr(aif_pkg::PG_CTRL, 4'h0, 16'h0004);
    wr(aif_pkg::PG_FOUR_OUT, 4'h0, 16'h0C33);
    wr(aif_pkg::PG_FOUR_OUT, 4'h2, 16'h4000);
    wr(aif_pkg::PG_FOUR_OUT, 4'h3, 16'h3FFF);
    rc("four out ch3 scaled", aif_pkg::PG_FOUR_OUT, 4'h3, 16'h3FFC);
    check("four out code0 scaled", {17'h0, four_out_code[0]}, 32'h0000_1860);
    check("four out code1 scaled", {17'h0, four_out_code[1]}, 32'h0000_0000);
    check("four out code2 scaled", {17'h0, four_out_code[2]}, 32'h0000_7FF8);
    check("four out code3 scaled", {17'h0, four_out_code[3]}, 32'h0000_7FF8);
    rc("four out range", aif_pkg::PG_FOUR_OUT_ST, 4'h1, 16'h0024);
    rc("four out status", aif_pkg::PG_FOUR_OUT_ST, 4'h0, 16'h0006);
    wr(aif_pkg::PG_FOUR_OUT, 4'h1, 16'h0000);
    wr(aif_pkg::PG_FOUR_OUT, 4'h2, 16'h0000);
    conv.set_faults(3'b001);
    repeat (3) @(posedge sys_clk);
    rc("four out range clear", aif_pkg::PG_FOUR_OUT_ST, 4'h1, 16'h0000);
    rc("four out status fault", aif_pkg::PG_FOUR_OUT_ST, 4'h0, 16'h000F);
    conv.set_faults(3'b000);
    bus(1'b1, aif_pkg::PG_FOUR_OUT, 4'h3, 16'h1238, 4'h2);
    rc("four out byte lane", aif_pkg::PG_FOUR_OUT, 4'h3, 16'h12FC);
    wr(3'h6, 4'h0, 16'hFFFF);
    rc("unmapped", 3'h6, 4'h0, 16'h0000);
    // Enable low: image holds, request waits until enable returns
    @(posedge sys_clk);
    ce <= 1'b0;
    conv.set_four(3, 15'h1000, 1'b0, 1'b0, 1'b0);
    fork
      rc("frozen image", aif_pkg::PG_FOUR_IN, 4'h3, 16'h0008);
      begin
        repeat (4) @(posedge sys_clk);
        ce <= 1'b1;
      end
    join
    rc("thawed image", aif_pkg::PG_FOUR_IN, 4'h3, 16'h1000);
    summarize();
  end
endmodule
